// [logic/fault_status_cfg.svh]
`ifndef FAULT_STATUS_CFG_SVH
`define FAULT_STATUS_CFG_SVH

// Register byte offsets; the map is our own and leaves room for growth.
`define FS_OFF_STATUS     12'h000
`define FS_OFF_ENABLE     12'h004
`define FS_OFF_CONTROL    12'h008
`define FS_OFF_POLL       12'h00C
`define FS_ADDR_W         12

// Fault status bit positions.
`define FS_BIT_PRINT      0
`define FS_BIT_NOCLK      1
`define FS_BIT_ALEV_A     2
`define FS_BIT_ALEV_B     3
`define FS_BIT_TEST       4
`define FS_BIT_CAL        5
`define FS_BIT_WARM       6
`define FS_BIT_OVERFLOW   7

// Serial poll byte: error summary bit; control register: clear-status bit.
`define POLL_BIT_ERR      2
`define CTRL_BIT_CLS      0

// Service request enables sit in the second byte lane of the poll register.
`define POLL_SRQEN_LSB    8
`define POLL_SRQEN_LANE   1

// Reset values.
`define FS_RST_STATUS     8'h00
`define FS_RST_ENABLE     8'h00
`define FS_RST_SRQEN      8'h00

// AXI responses.
`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2

`endif

// [logic/fault_pkg.sv]
package fault_pkg;

    typedef struct packed {
        logic print_fail;
        logic ref_missing;
        logic alev_a_lost;
        logic alev_b_lost;
        logic selftest_fail;
        logic autocal_fail;
        logic warmup_done;
        logic counter_overflow_or_zero_divide;
    } fault_events_t;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_RESP
    } rd_state_t;

    typedef struct packed {
        logic [7:0] bits;
        logic [7:0] prev;
    } edge_state_t;

endpackage : fault_pkg

// [logic/srq_edge.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_cfg.svh"

// Raises one pulse per clear-to-set transition of an enabled poll bit.
module srq_edge
    import fault_pkg::*;
(
    // Clock and reset.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Poll byte and enables.
    input  wire logic [7:0] poll_bits,
    input  wire logic [7:0] srq_enable,
    // Request pulse.
    output logic            srq_pulse
);

    edge_state_t st_r;
    edge_state_t st_nxt;
    logic        pulse_r;
    logic        pulse_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.bits = poll_bits & srq_enable;
        st_nxt.prev = st_r.bits;
        pulse_nxt   = |(st_r.bits & ~st_r.prev); // see RULE10
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r    <= '0;
            pulse_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign srq_pulse = pulse_r;

    AST_SRQ_ONCE: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE10
        srq_pulse |=> !srq_pulse)
        else $error("service request pulse repeated");

endmodule : srq_edge

`default_nettype wire

// [logic/fault_status_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_cfg.svh"

// Behaviour
// RULE1 - Print or plot failure sets status bit 0.
// RULE2 - Missing 10 MHz reference sets status bit 1.
// RULE3 - Channel A autolevel trigger loss sets bit 2; channel B sets bit 3.
// RULE4 - Self-test failure sets status bit 4.
// RULE5 - Autocalibration failure sets status bit 5.
// RULE6 - Warm-up completion after power-on sets status bit 6.
// RULE7 - Counter overflow or ratio divide by zero sets status bit 7.
// RULE8 - Bits stay latched until the register is read or clear-status arrives.
// RULE9 - Poll bit 2 is high while any enabled status bit is set.
// RULE10 - Service request only on clear-to-set of an enabled poll bit.
// RULE11 - Read-clear is atomic; same-cycle events survive to next read.
module fault_status_regs
    import fault_pkg::*;
(
    // Clock and reset.
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // Fault events, one-cycle pulses or levels on this clock.
    input  wire fault_events_t events,
    input  wire logic          clear_status,
    // AXI4-Lite write address.
    input  wire logic [11:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    // AXI4-Lite write data.
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // AXI4-Lite read address.
    input  wire logic [11:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    // Status outputs.
    output logic [7:0]         poll_byte,
    output logic               error_summary,
    output logic               service_request
);

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  enable;
        logic [7:0]  srq_en;
        logic        aw_got;
        logic [11:0] aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        summary;
        logic [7:0]  poll;
    } regs_t;

    regs_t  s_r;
    regs_t  s_nxt;
    logic   srq_pulse;
    logic   srq_r;

    function automatic logic [7:0] byte_write(input logic [7:0] old, input logic [31:0] d,
                                              input logic [3:0] strb);
        byte_write = strb[0] ? d[7:0] : old;
    endfunction : byte_write

    function automatic logic [7:0] events_vec(input fault_events_t e);
        logic [7:0] v;
        v = 8'h00;
        v[`FS_BIT_PRINT]  = e.print_fail;     // see RULE1
        v[`FS_BIT_NOCLK]  = e.ref_missing;    // see RULE2
        v[`FS_BIT_ALEV_A] = e.alev_a_lost;    // see RULE3
        v[`FS_BIT_ALEV_B] = e.alev_b_lost;    // see RULE3
        v[`FS_BIT_TEST]   = e.selftest_fail;  // see RULE4
        v[`FS_BIT_CAL]    = e.autocal_fail;   // see RULE5
        v[`FS_BIT_WARM]   = e.warmup_done;    // see RULE6
        v[`FS_BIT_OVERFLOW] = e.counter_overflow_or_zero_divide; // see RULE7
        events_vec = v;
    endfunction : events_vec

    logic [7:0] ev;
    logic       rd_take;
    logic       rd_status;
    logic       wr_do;
    logic       wr_ok;
    logic [7:0] clr_mask;
    logic [7:0] srq_src;

    always_comb begin
        s_nxt     = s_r;
        ev        = events_vec(events);
        rd_take   = s_axi_arvalid && s_r.arready;
        rd_status = rd_take && (s_axi_araddr == `FS_OFF_STATUS);
        wr_do     = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        wr_ok     = 1'b0;
        clr_mask  = 8'h00;

        // Write channels are taken independently, in either order.
        if (s_axi_awvalid && !s_r.aw_got) begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_got) begin
            s_nxt.w_got  = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        if (wr_do) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            case (s_r.aw_addr)
                `FS_OFF_STATUS: wr_ok = 1'b1;
                `FS_OFF_ENABLE: begin
                    wr_ok        = 1'b1;
                    s_nxt.enable = byte_write(s_r.enable, s_r.w_data, s_r.w_strb);
                end
                `FS_OFF_CONTROL: begin
                    wr_ok = 1'b1;
                    if (s_r.w_strb[0] && s_r.w_data[`CTRL_BIT_CLS]) begin
                        clr_mask = 8'hFF; // see RULE8
                    end
                end
                `FS_OFF_POLL: begin
                    wr_ok        = 1'b1;
                    s_nxt.srq_en = byte_write(s_r.srq_en, s_r.w_data >> `POLL_SRQEN_LSB,
                                              s_r.w_strb >> `POLL_SRQEN_LANE);
                end
                default: wr_ok = 1'b0;
            endcase
            s_nxt.bresp = wr_ok ? `AXI_OKAY : `AXI_SLVERR;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // One read at a time: arready drops until the data is taken.
        if (rd_take) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid  = 1'b1;
            s_nxt.rresp   = `AXI_OKAY;
            s_nxt.rdata   = 32'h0000_0000;
            case (s_axi_araddr)
                `FS_OFF_STATUS:  s_nxt.rdata[7:0] = s_r.status;
                `FS_OFF_ENABLE:  s_nxt.rdata[7:0] = s_r.enable;
                `FS_OFF_CONTROL: s_nxt.rdata      = 32'h0000_0000;
                `FS_OFF_POLL:    s_nxt.rdata      = {16'h0000, s_r.srq_en, s_r.poll};
                default:         s_nxt.rresp      = `AXI_SLVERR;
            endcase
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid  = 1'b0;
            s_nxt.arready = 1'b1;
        end

        // Snapshot is taken above from the old value; the clear covers only
        // what was returned, while new events set in the same cycle win.
        if (rd_status || clear_status) begin
            clr_mask = 8'hFF; // see RULE8
        end
        s_nxt.status = (s_r.status & ~clr_mask) | ev; // see RULE11

        s_nxt.summary = |(s_nxt.status & s_nxt.enable); // see RULE9
        s_nxt.poll    = 8'h00;
        s_nxt.poll[`POLL_BIT_ERR] = s_nxt.summary; // see RULE9
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r         <= '0;
            s_r.status  <= `FS_RST_STATUS;
            s_r.enable  <= `FS_RST_ENABLE;
            s_r.srq_en  <= `FS_RST_SRQEN;
            s_r.arready <= 1'b1;
            srq_r       <= 1'b0;
        end else begin
            s_r   <= s_nxt;
            srq_r <= srq_pulse;
        end
    end

    // The extra stage in srq_r keeps the pin straight off a flop of this module;
    // it costs one cycle of request latency, which the host never notices.
    srq_edge srq_edge_i (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .poll_bits  (s_r.poll),
        .srq_enable (s_r.srq_en),
        .srq_pulse  (srq_pulse)
    );

    assign s_axi_awready   = !s_r.aw_got;
    assign s_axi_wready    = !s_r.w_got;
    assign s_axi_bvalid    = s_r.bvalid;
    assign s_axi_bresp     = s_r.bresp;
    assign s_axi_arready   = s_r.arready;
    assign s_axi_rvalid    = s_r.rvalid;
    assign s_axi_rdata     = s_r.rdata;
    assign s_axi_rresp     = s_r.rresp;
    assign poll_byte       = s_r.poll;
    assign error_summary   = s_r.summary;
    assign service_request = srq_r;

    assign srq_src = s_r.poll & s_r.srq_en;

    sequence status_read_s;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `FS_OFF_STATUS;
    endsequence

    sequence ctrl_clear_s;
        wr_do && s_r.aw_addr == `FS_OFF_CONTROL && s_r.w_strb[0] && s_r.w_data[`CTRL_BIT_CLS];
    endsequence

    AST_PRINT_SET: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE1
        events.print_fail |=> s_r.status[`FS_BIT_PRINT])
        else $error("print failure not latched");

    AST_NOCLK_SET: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE2
        events.ref_missing |=> s_r.status[`FS_BIT_NOCLK])
        else $error("missing reference not latched");

    AST_ALEV_A_SET: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE3
        events.alev_a_lost |=> s_r.status[`FS_BIT_ALEV_A])
        else $error("channel A autolevel loss not latched");

    AST_ALEV_B_SET: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE3
        events.alev_b_lost |=> s_r.status[`FS_BIT_ALEV_B])
        else $error("channel B autolevel loss not latched");

    AST_TEST_SET: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE4
        events.selftest_fail |=> s_r.status[`FS_BIT_TEST])
        else $error("self-test failure not latched");

    AST_CAL_SET: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE5
        events.autocal_fail |=> s_r.status[`FS_BIT_CAL])
        else $error("calibration failure not latched");

    AST_WARM_SET: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE6
        events.warmup_done |=> s_r.status[`FS_BIT_WARM])
        else $error("warm-up not latched");

    AST_OVERFLOW_SET: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE7
        events.counter_overflow_or_zero_divide |=> s_r.status[`FS_BIT_OVERFLOW])
        else $error("overflow not latched");

    AST_LATCH_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE8
        !(s_axi_arvalid && s_axi_arready && s_axi_araddr == `FS_OFF_STATUS) && !clear_status
        && !(wr_do && s_r.aw_addr == `FS_OFF_CONTROL)
        |=> ((s_r.status & $past(s_r.status)) == $past(s_r.status)))
        else $error("status bit dropped without a clear");

    AST_CLEAR_CMD: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE8
        clear_status |=> s_r.status == $past(ev))
        else $error("clear-status command left stale bits");

    AST_CTRL_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE8
        ctrl_clear_s |=> s_r.status == $past(ev))
        else $error("control write did not clear status");

    AST_SUMMARY: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE9
        error_summary == |(s_r.status & s_r.enable))
        else $error("summary does not follow enabled status");

    AST_POLL_BYTE: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE9
        poll_byte == (8'(error_summary) << `POLL_BIT_ERR))
        else $error("poll byte does not carry the summary alone");

    AST_SRQ_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE10
        service_request |-> |($past(srq_src, 3) & ~$past(srq_src, 4)))
        else $error("service request without a rising enabled poll bit");

    AST_READ_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE11
        status_read_s |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(s_r.status)
        && s_r.status == $past(ev))
        else $error("read-clear lost a value or an event");

    AST_READ_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted while one is outstanding");

    AST_WR_UNMAPPED: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_do && s_r.aw_addr > `FS_OFF_POLL |=> s_axi_bresp == `AXI_SLVERR)
        else $error("unmapped write not refused");

    AST_RD_UNMAPPED: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr > `FS_OFF_POLL |=> s_axi_rresp == `AXI_SLVERR)
        else $error("unmapped read not refused");

endmodule : fault_status_regs

`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_cfg.svh"

module testbench
    import fault_pkg::*;
;
    logic          aclk = 0;
    logic          aresetn = 0;
    fault_events_t events = '0;
    logic          clear_status = 0;
    logic [11:0]   awaddr = 0, araddr = 0;
    logic [31:0]   wdata = 0, rdata;
    logic [3:0]    wstrb = 4'hF;
    logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic          awready, wready, bvalid, arready, rvalid, service_request, error_summary;
    logic [1:0]    bresp, rresp;
    logic [7:0]    poll_byte, p, q;
    int            err_count = 0, checked = 0, srq_cnt = 0, s0, i;
    int            seed = 32'hD15BC849;
    logic [33:0]   expq[$];
    logic [33:0]   bq[$];

    always #10 aclk = ~aclk;

    fault_status_regs fault_status_regs_i (
        .aclk(aclk), .aresetn(aresetn), .events(events), .clear_status(clear_status),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .poll_byte(poll_byte),
        .error_summary(error_summary), .service_request(service_request)
    );

    task chk(input string n, input logic [33:0] e, input logic [33:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Read results are judged here, in order of issue, so a late answer still lines up.
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (expq.size() == 0) chk("unexpected read", 34'h0, {rresp, rdata});
            else chk("read data", expq.pop_front(), {rresp, rdata});
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            if (bq.size() == 0) chk("unexpected response", 34'h0, {32'h0, bresp});
            else chk("write response", bq.pop_front(), {32'h0, bresp});
        end
    end

    always @(posedge aclk) if (service_request === 1'b1) srq_cnt++;

    function automatic logic [33:0] ok(input logic [7:0] v);
        ok = {26'h0, v};
    endfunction : ok

    // The struct lists the overflow event last, so the status byte is the event byte reversed.
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int k = 0; k < 8; k++) rev8[k] = v[7 - k];
    endfunction : rev8

    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        bq.push_back({32'h0, r});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw = 1;
                awvalid <= 0;
            end
            if (wvalid && wready === 1'b1) begin
                w = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 0;
    endtask : wr

    task rd(input logic [11:0] a, input logic [33:0] e);
        @(posedge aclk);
        expq.push_back(e);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 0;
    endtask : rd

    task pulse(input logic [7:0] v);
        @(posedge aclk);
        events <= fault_events_t'(v);
        @(posedge aclk);
        events <= '0;
    endtask : pulse

    task end_sim;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    initial begin
        #(20 * 20000);
        err_count++;
        $display("watchdog expired");
        end_sim;
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        rd(`FS_OFF_STATUS, ok(`FS_RST_STATUS));
        rd(`FS_OFF_ENABLE, ok(`FS_RST_ENABLE));
        rd(12'h010, {`AXI_SLVERR, 32'h0});
        wr(12'h010, 32'h1, `AXI_SLVERR);
        $display("test reset and map done");
        for (i = 0; i < 8; i++) begin
            pulse(8'h80 >> i);
            rd(`FS_OFF_STATUS, ok(8'h01 << i));
            rd(`FS_OFF_STATUS, ok(8'h00));
        end
        $display("test event bits done");
        repeat (6) begin
            p = $random(seed);
            q = $random(seed);
            pulse(p);
            pulse(q);
            repeat (3) @(posedge aclk);
            rd(`FS_OFF_STATUS, ok(rev8(p | q)));
        end
        pulse(8'hFF);
        @(posedge aclk);
        clear_status <= 1;
        @(posedge aclk);
        clear_status <= 0;
        rd(`FS_OFF_STATUS, ok(8'h00));
        pulse(8'h3C);
        wr(`FS_OFF_CONTROL, 32'h1, `AXI_OKAY);
        rd(`FS_OFF_STATUS, ok(8'h00));
        $display("test sticky and clear done");
        @(posedge aclk);
        events <= fault_events_t'(8'h01);
        rd(`FS_OFF_STATUS, ok(8'h80));
        events <= '0;
        rd(`FS_OFF_STATUS, ok(8'h80));
        rd(`FS_OFF_STATUS, ok(8'h00));
        $display("test read collision done");
        wr(`FS_OFF_ENABLE, 32'h1, `AXI_OKAY);
        rd(`FS_OFF_ENABLE, ok(8'h01));
        wr(`FS_OFF_POLL, 32'h400, `AXI_OKAY);
        rd(`FS_OFF_POLL, {2'h0, 32'h400});
        s0 = srq_cnt;
        pulse(8'h40);
        repeat (4) @(posedge aclk);
        chk("summary masked", 34'h0, {33'h0, error_summary});
        pulse(8'h80);
        repeat (8) @(posedge aclk);
        chk("summary", 34'h1, {33'h0, error_summary});
        chk("poll byte", 34'h4, {26'h0, poll_byte});
        chk("request count", 34'h1, 34'(srq_cnt - s0));
        pulse(8'h80);
        repeat (8) @(posedge aclk);
        chk("request count", 34'h1, 34'(srq_cnt - s0));
        rd(`FS_OFF_STATUS, ok(8'h03));
        repeat (4) @(posedge aclk);
        chk("summary cleared", 34'h0, {33'h0, error_summary});
        pulse(8'h80);
        repeat (8) @(posedge aclk);
        chk("request count", 34'h2, 34'(srq_cnt - s0));
        $display("test summary and request done");
        end_sim;
    end
endmodule : testbench

`default_nettype wire
